// ### uss_bit_order.sv
// Registered data bit order converter between data word and line order.
`timescale 1ns/1ps
`default_nettype none

module uss_bit_order #(
  parameter int W = 10
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reverse,
  input wire logic [3:0] nbits,
  input wire logic [W-1:0] word_in,
  output logic [W-1:0] word_q
);

  logic [W-1:0] rev_w;

  // ----------------------------------------------------------------------
  // Per bit selection
  // ----------------------------------------------------------------------
  // Only the low nbits data bits are mirrored; a parity bit above them
  // keeps its place. The mapping is its own inverse, so one converter
  // serves both the transmit and the receive direction.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [3:0] src;
    assign src = 4'(nbits - 4'(i) - 4'd1);
    assign rev_w[i] = (reverse && (4'(i) < nbits)) ? word_in[src] : word_in[i];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= '0;
    end else begin
      word_q <= rev_w;
    end
  end

endmodule

`default_nettype wire

// ### uss_peer.sv
// Serial peer that holds the receive line low for a set number of bit times.
`timescale 1ns/1ps
`default_nettype none
module uss_peer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bit_tick,
  input wire logic go,
  input wire logic [4:0] low_ticks,
  output logic rx_pin,
  output logic busy
);
  logic [4:0] left_q;
  // ------------------------------------------------------------------
  // Line driver
  // ------------------------------------------------------------------
  // The line rests at mark, so a released line reads high as on a real bus.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pin <= 1'b1;
      busy <= 1'b0;
      left_q <= 5'h0;
    end else if (go) begin
      rx_pin <= 1'b0;
      busy <= 1'b1;
      left_q <= low_ticks;
    end else if (busy && bit_tick) begin
      left_q <= left_q - 5'h1;
      if (left_q == 5'h1) begin
        rx_pin <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### uss_pkg.sv
// Constants for the second UART status and control register block.
package uss_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] USS_STATUS_CTRL_TWO_OFS = 8'h05;
  localparam logic [7:0] USS_RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int USS_BIT_BREAK_FLAG = 7;
  localparam int USS_BIT_EDGE_FLAG = 6;
  localparam int USS_BIT_ORDER_REV = 5;
  localparam int USS_BIT_RX_INVERT = 4;
  localparam int USS_BIT_WAKE_IDLE = 3;
  localparam int USS_BIT_LONG_BREAK = 1;
  localparam int USS_BIT_RX_ACTIVE = 0;

  // ----------------------------------------------------------------------
  // Break thresholds in bit times, indexed by frame format class
  // ----------------------------------------------------------------------
  localparam logic [4:0] USS_BRK_NORM_0 = 5'd10;
  localparam logic [4:0] USS_BRK_NORM_1 = 5'd11;
  localparam logic [4:0] USS_BRK_NORM_2 = 5'd12;
  localparam logic [4:0] USS_BRK_NORM_3 = 5'd13;
  localparam logic [4:0] USS_BRK_LONG_0 = 5'd11;
  localparam logic [4:0] USS_BRK_LONG_1 = 5'd12;
  localparam logic [4:0] USS_BRK_LONG_2 = 5'd14;
  localparam logic [4:0] USS_BRK_LONG_3 = 5'd15;
  localparam logic [4:0] USS_BRK_CNT_MAX = 5'd31;

  // ----------------------------------------------------------------------
  // Data word sizes in bits, parity included
  // ----------------------------------------------------------------------
  localparam int USS_WORD_W = 10;
  localparam logic [3:0] USS_LEN_8 = 4'd8;
  localparam logic [3:0] USS_LEN_9 = 4'd9;
  localparam logic [3:0] USS_LEN_10 = 4'd10;

endpackage

// ### uss_status_two.sv
// Second UART status and control register with break, edge and bit order logic.
`timescale 1ns/1ps
`default_nettype none

module uss_status_two
  import uss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic rx_pin,
  input wire logic bit_tick,
  input wire logic char_9bit,
  input wire logic ten_bit_select,
  input wire logic parity_enable,
  input wire logic stop_bit_count,
  input wire logic rx_standby,
  input wire logic idle_detect,
  input wire logic rx_full_raw,
  input wire logic framing_error_raw,
  input wire logic brk_irq_en,
  input wire logic edge_irq_en,
  input wire logic [9:0] tx_data,
  input wire logic [9:0] rx_word,
  output logic rx_line_q,
  output logic [9:0] tx_word_q,
  output logic [9:0] rx_data_q,
  output logic rx_full_flag_set_q,
  output logic framing_error_flag_set_q,
  output logic idle_flag_set_q,
  output logic break_seen_q,
  output logic break_irq_q,
  output logic edge_irq_q,
  output logic bit_order_reverse_q,
  output logic rx_polarity_invert_q,
  output logic long_break_detect_en_q
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic break_detected_flag_q;
  logic rx_edge_flag_q;
  logic wake_idle_sets_flag_q;
  logic rx_active_q;
  logic line_prev_q;
  logic [4:0] low_cnt_q;
  logic brk_hit;
  logic edge_hit;
  logic sel;
  logic wr_hit;
  logic [1:0] fmt_class;
  logic [4:0] brk_thr;
  logic [3:0] nbits;
  logic [7:0] reg_value;

  assign sel = (reg_addr == USS_STATUS_CTRL_TWO_OFS);
  assign wr_hit = reg_wr && sel;

  // ----------------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------------
  // Changing the bit order or the wake idle choice mid frame is not
  // guarded here; software is expected to disable the paths first.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_order_reverse_q <= 1'b0;
    end else if (wr_hit) begin
      bit_order_reverse_q <= reg_wdata[USS_BIT_ORDER_REV];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_polarity_invert_q <= 1'b0;
    end else if (wr_hit) begin
      rx_polarity_invert_q <= reg_wdata[USS_BIT_RX_INVERT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_idle_sets_flag_q <= 1'b0;
    end else if (wr_hit) begin
      wake_idle_sets_flag_q <= reg_wdata[USS_BIT_WAKE_IDLE];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      long_break_detect_en_q <= 1'b0;
    end else if (wr_hit) begin
      long_break_detect_en_q <= reg_wdata[USS_BIT_LONG_BREAK];
    end
  end

  // ----------------------------------------------------------------------
  // Receive line conditioning
  // ----------------------------------------------------------------------
  // The inversion sits ahead of every receive consumer, so start, stop,
  // break and idle all see the same corrected level.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_line_q <= 1'b1;
    end else begin
      rx_line_q <= rx_pin ^ rx_polarity_invert_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_prev_q <= 1'b1;
    end else begin
      line_prev_q <= rx_line_q;
    end
  end

  // A falling corrected line is a falling pin edge without inversion and a
  // rising pin edge with it.
  assign edge_hit = line_prev_q && !rx_line_q;

  // ----------------------------------------------------------------------
  // Receiver active indication
  // ----------------------------------------------------------------------
  // A start edge outranks an idle report in the same cycle, so a frame that
  // begins just as the line goes idle still reads as active.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_active_q <= 1'b0;
    end else if (edge_hit) begin
      rx_active_q <= 1'b1;
    end else if (idle_detect) begin
      rx_active_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Break detection
  // ----------------------------------------------------------------------
  // Format class: 0 for 8 data bits and one stop, 1 for one step longer,
  // 2 for two steps or ten bit data, 3 for ten bit data with two stops.
  always_comb begin
    if (ten_bit_select) begin
      fmt_class = stop_bit_count ? 2'd3 : 2'd2;
    end else if (char_9bit) begin
      fmt_class = stop_bit_count ? 2'd2 : 2'd1;
    end else begin
      fmt_class = stop_bit_count ? 2'd1 : 2'd0;
    end
  end

  always_comb begin
    brk_thr = USS_BRK_NORM_0;
    if (long_break_detect_en_q) begin
      unique case (fmt_class)
        2'd0: brk_thr = USS_BRK_LONG_0;
        2'd1: brk_thr = USS_BRK_LONG_1;
        2'd2: brk_thr = USS_BRK_LONG_2;
        2'd3: brk_thr = USS_BRK_LONG_3;
      endcase
    end else begin
      unique case (fmt_class)
        2'd0: brk_thr = USS_BRK_NORM_0;
        2'd1: brk_thr = USS_BRK_NORM_1;
        2'd2: brk_thr = USS_BRK_NORM_2;
        2'd3: brk_thr = USS_BRK_NORM_3;
      endcase
    end
  end

  // Counts bit ticks while the corrected line is low. The count saturates
  // so a stuck low line reports one break, not one every 32 bit times.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= '0;
    end else if (rx_line_q) begin
      low_cnt_q <= '0;
    end else if (bit_tick && (low_cnt_q != USS_BRK_CNT_MAX)) begin
      low_cnt_q <= low_cnt_q + 5'd1;
    end
  end

  assign brk_hit = !rx_line_q && bit_tick && (5'(low_cnt_q + 5'd1) == brk_thr);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      break_seen_q <= 1'b0;
    end else begin
      break_seen_q <= brk_hit;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // Only the long break mode arms the break flag; a normal length break
  // still pulses break_seen_q for the rest of the receiver.
  // A new event in the clearing cycle keeps the flag set, so no break or
  // edge is lost to a racing software clear.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      break_detected_flag_q <= 1'b0;
    end else if (brk_hit && long_break_detect_en_q) begin
      break_detected_flag_q <= 1'b1;
    end else if (wr_hit && reg_wdata[USS_BIT_BREAK_FLAG]) begin
      break_detected_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_edge_flag_q <= 1'b0;
    end else if (edge_hit) begin
      rx_edge_flag_q <= 1'b1;
    end else if (wr_hit && reg_wdata[USS_BIT_EDGE_FLAG]) begin
      rx_edge_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------------
  // These follow the flags one cycle late, which keeps the outputs
  // registered at the cost of one cycle of latency.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      break_irq_q <= 1'b0;
    end else begin
      break_irq_q <= break_detected_flag_q && brk_irq_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_irq_q <= 1'b0;
    end else begin
      edge_irq_q <= rx_edge_flag_q && edge_irq_en;
    end
  end

  // ----------------------------------------------------------------------
  // Flags of the receive path
  // ----------------------------------------------------------------------
  // With long break on, a zero character ends in a low stop bit; both flags
  // are held off so such a character never reaches software as data.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      framing_error_flag_set_q <= 1'b0;
    end else begin
      framing_error_flag_set_q <= framing_error_raw && !long_break_detect_en_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_full_flag_set_q <= 1'b0;
    end else begin
      rx_full_flag_set_q <= rx_full_raw && !long_break_detect_en_q;
    end
  end

  // Outside standby every idle character sets the flag; in standby the wake
  // idle bit decides, since that idle character is what wakes the receiver.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_flag_set_q <= 1'b0;
    end else begin
      idle_flag_set_q <= idle_detect && (!rx_standby || wake_idle_sets_flag_q);
    end
  end

  // ----------------------------------------------------------------------
  // Bit order
  // ----------------------------------------------------------------------
  // Parity, when enabled, takes the top slot of the word and stays put, so
  // the mirrored span shrinks by one.
  always_comb begin
    if (ten_bit_select) begin
      nbits = USS_LEN_10;
    end else if (char_9bit) begin
      nbits = USS_LEN_9;
    end else begin
      nbits = USS_LEN_8;
    end
    if (parity_enable) begin
      nbits = 4'(nbits - 4'd1);
    end
  end

  uss_bit_order #(
    .W(USS_WORD_W)
  ) u_tx_order (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reverse(bit_order_reverse_q),
    .nbits(nbits),
    .word_in(tx_data),
    .word_q(tx_word_q)
  );

  uss_bit_order #(
    .W(USS_WORD_W)
  ) u_rx_order (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reverse(bit_order_reverse_q),
    .nbits(nbits),
    .word_in(rx_word),
    .word_q(rx_data_q)
  );

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  // Bit two has no function in this block and always reads zero.
  always_comb begin
    reg_value = USS_RESET_VALUE;
    reg_value[USS_BIT_BREAK_FLAG] = break_detected_flag_q;
    reg_value[USS_BIT_EDGE_FLAG] = rx_edge_flag_q;
    reg_value[USS_BIT_ORDER_REV] = bit_order_reverse_q;
    reg_value[USS_BIT_RX_INVERT] = rx_polarity_invert_q;
    reg_value[USS_BIT_WAKE_IDLE] = wake_idle_sets_flag_q;
    reg_value[USS_BIT_LONG_BREAK] = long_break_detect_en_q;
    reg_value[USS_BIT_RX_ACTIVE] = rx_active_q;
  end

  // Read data stand only in the cycle after the strobe and are zero
  // otherwise, including for any unmapped address.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= '0;
    end else if (reg_rd && sel) begin
      reg_rdata_q <= reg_value;
    end else begin
      reg_rdata_q <= '0;
    end
  end

endmodule

`default_nettype wire

// ### uss_status_two_assertions.sv
// Concurrent checks on the ports of the second UART status and control register.
`timescale 1ns/1ps
`default_nettype none
module uss_status_two_chk
  import uss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic rx_pin,
  input wire logic bit_tick,
  input wire logic rx_standby,
  input wire logic idle_detect,
  input wire logic rx_full_raw,
  input wire logic framing_error_raw,
  input wire logic brk_irq_en,
  input wire logic edge_irq_en,
  input wire logic [9:0] tx_data,
  input wire logic rx_line_q,
  input wire logic [9:0] tx_word_q,
  input wire logic rx_full_flag_set_q,
  input wire logic framing_error_flag_set_q,
  input wire logic idle_flag_set_q,
  input wire logic break_seen_q,
  input wire logic break_irq_q,
  input wire logic edge_irq_q,
  input wire logic bit_order_reverse_q,
  input wire logic rx_polarity_invert_q,
  input wire logic long_break_detect_en_q
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr;
    reg_wr && reg_addr == USS_STATUS_CTRL_TWO_OFS;
  endsequence
  sequence s_edge;
    $fell(rx_line_q) ##1 edge_irq_en;
  endsequence
  property p_wr_fields;
    s_wr |=> bit_order_reverse_q == $past(reg_wdata[5]) &&
      rx_polarity_invert_q == $past(reg_wdata[4]) && long_break_detect_en_q == $past(reg_wdata[1]);
  endproperty
  property p_hold;
    !(reg_wr && reg_addr == USS_STATUS_CTRL_TWO_OFS) |=> $stable(bit_order_reverse_q) &&
      $stable(rx_polarity_invert_q) && $stable(long_break_detect_en_q);
  endproperty
  property p_rd_quiet;
    !(reg_rd && reg_addr == USS_STATUS_CTRL_TWO_OFS) |=> reg_rdata_q == 8'h00;
  endproperty
  property p_line;
    rx_pin == rx_pin |=> rx_line_q == ($past(rx_pin) ^ $past(rx_polarity_invert_q));
  endproperty
  property p_full;
    rx_full_raw |=> rx_full_flag_set_q == !$past(long_break_detect_en_q);
  endproperty
  property p_fe;
    framing_error_raw |=> framing_error_flag_set_q == !$past(long_break_detect_en_q);
  endproperty
  property p_idle;
    idle_detect && !rx_standby |=> idle_flag_set_q;
  endproperty
  property p_edge_irq;
    s_edge |=> edge_irq_q;
  endproperty
  property p_brk_irq;
    break_seen_q && long_break_detect_en_q && brk_irq_en |=> break_irq_q;
  endproperty
  property p_brk_tick;
    break_seen_q |-> $past(bit_tick) && !$past(rx_line_q);
  endproperty
  property p_tx_plain;
    !bit_order_reverse_q |=> tx_word_q == $past(tx_data);
  endproperty
  a_wr_fields: assert property (p_wr_fields) else $error("register write not taken");
  a_hold: assert property (p_hold) else $error("control bit changed without write");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  a_line: assert property (p_line) else $error("receive line polarity wrong");
  a_full: assert property (p_full) else $error("receive full gating wrong");
  a_fe: assert property (p_fe) else $error("framing error gating wrong");
  a_idle: assert property (p_idle) else $error("idle flag missing");
  a_edge_irq: assert property (p_edge_irq) else $error("edge request missing");
  a_brk_irq: assert property (p_brk_irq) else $error("break request missing");
  a_brk_tick: assert property (p_brk_tick) else $error("break without low tick");
  a_tx_plain: assert property (p_tx_plain) else $error("plain bit order wrong");
endmodule
bind uss_status_two uss_status_two_chk u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .rx_pin(rx_pin),
  .bit_tick(bit_tick), .rx_standby(rx_standby), .idle_detect(idle_detect),
  .rx_full_raw(rx_full_raw), .framing_error_raw(framing_error_raw), .brk_irq_en(brk_irq_en),
  .edge_irq_en(edge_irq_en), .tx_data(tx_data), .rx_line_q(rx_line_q), .tx_word_q(tx_word_q),
  .rx_full_flag_set_q(rx_full_flag_set_q), .framing_error_flag_set_q(framing_error_flag_set_q),
  .idle_flag_set_q(idle_flag_set_q), .break_seen_q(break_seen_q), .break_irq_q(break_irq_q),
  .edge_irq_q(edge_irq_q), .bit_order_reverse_q(bit_order_reverse_q),
  .rx_polarity_invert_q(rx_polarity_invert_q), .long_break_detect_en_q(long_break_detect_en_q)
);
`default_nettype wire

// ### uss_status_two_tb_top.sv
// Self-checking testbench for the second UART status and control register.
`timescale 1ns/1ps
`default_nettype none
module uss_status_two_tb_top
  import uss_pkg::*;
;
  logic sys_clk, rst_b, reg_wr, reg_rd, bit_tick, char_9bit, ten_bit_select, parity_enable;
  logic stop_bit_count, rx_standby, idle_detect, rx_full_raw, framing_error_raw, go, busy;
  logic brk_irq_en, edge_irq_en, rx_pin, rx_line_q, rx_full_flag_set_q, break_seen_q;
  logic framing_error_flag_set_q, idle_flag_set_q, break_irq_q, edge_irq_q;
  logic bit_order_reverse_q, rx_polarity_invert_q, long_break_detect_en_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [9:0] tx_data, rx_word, tx_word_q, rx_data_q;
  logic [4:0] low_ticks;
  logic [1:0] tcnt;
  int mismatches, cmp_count, hits, n_full, n_fe, n_idle;
  int thr[8] = '{10, 11, 12, 13, 11, 12, 14, 15};
  uss_status_two dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .rx_pin(rx_pin), .bit_tick(bit_tick), .char_9bit(char_9bit),
    .ten_bit_select(ten_bit_select), .parity_enable(parity_enable),
    .stop_bit_count(stop_bit_count), .rx_standby(rx_standby), .idle_detect(idle_detect),
    .rx_full_raw(rx_full_raw), .framing_error_raw(framing_error_raw),
    .brk_irq_en(brk_irq_en), .edge_irq_en(edge_irq_en), .tx_data(tx_data),
    .rx_word(rx_word), .rx_line_q(rx_line_q), .tx_word_q(tx_word_q), .rx_data_q(rx_data_q),
    .rx_full_flag_set_q(rx_full_flag_set_q), .framing_error_flag_set_q(framing_error_flag_set_q),
    .idle_flag_set_q(idle_flag_set_q), .break_seen_q(break_seen_q), .break_irq_q(break_irq_q),
    .edge_irq_q(edge_irq_q), .bit_order_reverse_q(bit_order_reverse_q),
    .rx_polarity_invert_q(rx_polarity_invert_q), .long_break_detect_en_q(long_break_detect_en_q));
  uss_peer peer (.sys_clk(sys_clk), .rst_b(rst_b), .bit_tick(bit_tick), .go(go),
    .low_ticks(low_ticks), .rx_pin(rx_pin), .busy(busy));
  // ------------------------------------------------------------------
  // Clock, bit time and monitors
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h2);
    if (break_seen_q === 1'b1) hits++;
    if (rx_full_flag_set_q === 1'b1) n_full++;
    if (framing_error_flag_set_q === 1'b1) n_fe++;
    if (idle_flag_set_q === 1'b1) n_idle++;
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkc(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Reads wait a few cycles so flags launched by the last write have landed.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    repeat (3) @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({2'b00, reg_rdata_q}, {2'b00, e});
  endtask
  task automatic launch(input int n);
    @(posedge sys_clk);
    while (bit_tick !== 1'b1) @(posedge sys_clk);
    go <= 1'b1;
    low_ticks <= 5'(n);
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  task automatic land();
    @(posedge sys_clk);
    for (int k = 0; k < 300 && busy; k++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pulse_raw();
    @(posedge sys_clk);
    {rx_full_raw, framing_error_raw, idle_detect} <= 3'b111;
    @(posedge sys_clk);
    {rx_full_raw, framing_error_raw, idle_detect} <= 3'b000;
    repeat (2) @(posedge sys_clk);
  endtask
  function automatic logic [9:0] ordr(input logic [9:0] v, input logic r, input int nb);
    logic [9:0] o;
    o = v;
    if (r) for (int i = 0; i < nb; i++) o[i] = v[nb - 1 - i];
    return o;
  endfunction
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int nb;
    {reg_wr, reg_rd, char_9bit, ten_bit_select, parity_enable, stop_bit_count} = '0;
    {rx_standby, idle_detect, rx_full_raw, framing_error_raw, brk_irq_en, go} = '0;
    {reg_addr, reg_wdata, tx_data, rx_word, low_ticks, tcnt} = '0;
    bit_tick = 1'b0;
    edge_irq_en = 1'b0;
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h00);
    wr(8'h04, 8'hFF);
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h00);
    rd(8'h06, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(USS_STATUS_CTRL_TWO_OFS, {2'b00, i[3], 5'h0});
      char_9bit <= i[1];
      ten_bit_select <= i[2];
      parity_enable <= i[0];
      tx_data <= 10'h2C5 ^ 10'(i);
      rx_word <= 10'h13A ^ 10'(i);
      nb = (i[2] ? 10 : (i[1] ? 9 : 8)) - int'(i[0]);
      repeat (2) @(posedge sys_clk);
      #1 chk(tx_word_q, ordr(tx_data, i[3], nb));
      chk(rx_data_q, ordr(rx_word, i[3], nb));
    end
    wr(USS_STATUS_CTRL_TWO_OFS, 8'h10);
    edge_irq_en <= 1'b1;
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h51);
    chk({9'h0, edge_irq_q}, 10'h001);
    wr(USS_STATUS_CTRL_TWO_OFS, 8'h50);
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h11);
    launch(3);
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h11);
    land();
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h51);
    wr(USS_STATUS_CTRL_TWO_OFS, 8'h10);
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h51);
    wr(USS_STATUS_CTRL_TWO_OFS, 8'h40);
    rd(USS_STATUS_CTRL_TWO_OFS, 8'h01);
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      char_9bit <= (i[1:0] == 2'h1);
      ten_bit_select <= i[1];
      stop_bit_count <= (i[1:0] == 2'h3);
      parity_enable <= 1'b0;
      brk_irq_en <= i[0];
      wr(USS_STATUS_CTRL_TWO_OFS, {2'b11, 4'h0, i[2], 1'b0});
      hits = 0;
      launch(thr[i] - 1);
      land();
      chkc(hits, 0);
      launch(thr[i]);
      land();
      chkc(hits, 1);
      rd(USS_STATUS_CTRL_TWO_OFS, {i[2], 1'b1, 4'h0, i[2], 1'b1});
      chk({9'h0, break_irq_q}, {9'h0, i[2] & i[0]});
      wr(USS_STATUS_CTRL_TWO_OFS, {6'h00, i[2], 1'b0});
      rd(USS_STATUS_CTRL_TWO_OFS, {i[2], 1'b1, 4'h0, i[2], 1'b1});
      n_full = 0;
      n_fe = 0;
      pulse_raw();
      chkc(n_full + 2 * n_fe, 3 * (1 - int'(i[2])));
    end
    for (int i = 0; i < 4; i++) begin
      wr(USS_STATUS_CTRL_TWO_OFS, {4'h0, i[0], 3'b000});
      rx_standby <= i[1];
      n_idle = 0;
      pulse_raw();
      chkc(n_idle, (i[1] && !i[0]) ? 0 : 1);
    end
    summarize();
  end
endmodule
`default_nettype wire
